// ==== asp_pkg.sv ====
// Constants, states and register layout for the serial control port
package asp_pkg;

  // Control byte and result frame shape
  localparam int unsigned CTRL_BITS = 8;
  localparam int unsigned TRACK_BIT = 5;
  localparam int unsigned LEAD_ZEROS = 3;
  localparam int unsigned RES_BITS = 10;
  localparam int unsigned SUB_BITS = 2;
  localparam int unsigned TRAIL_ZEROS = 1;
  localparam int unsigned CODE_BITS = RES_BITS + SUB_BITS;
  localparam int unsigned FRAME_BITS =
    LEAD_ZEROS + CODE_BITS + TRAIL_ZEROS;

  // Widths of the counters
  localparam int unsigned CNT_W = 4;
  localparam int unsigned STEP_W = 5;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CNT_TRACK = 4'h5;
  localparam logic [CNT_W-1:0] CNT_HOLD = 4'h8;
  localparam logic [STEP_W-1:0] STEP_ONE = 5'h01;
  // Step on whose rising edge the strobe rises (MSB leaves on step 4)
  localparam logic [STEP_W-1:0] STEP_STROBE = 5'h03;
  localparam logic [STEP_W-1:0] STEP_LAST = 5'h10;

  // Control byte field positions
  localparam int unsigned CB_START = 7;
  localparam int unsigned CB_SEL_HI = 6;
  localparam int unsigned CB_SEL_LO = 4;
  localparam int unsigned CB_UNI = 3;
  localparam int unsigned CB_SGL = 2;
  localparam int unsigned CB_PM_HI = 1;
  localparam int unsigned CB_PM_LO = 0;

  // Reset values
  localparam logic [CTRL_BITS-1:0] CTRL_RST = 8'h00;
  localparam logic [FRAME_BITS-1:0] FRAME_RST = 16'h0000;

  // Synchroniser lanes: 0 chip select, 1 clock, 2 data, 3 shutdown
  localparam int unsigned SYNC_W = 4;
  localparam logic [SYNC_W-1:0] SYNC_RST = 4'h9;
  localparam int unsigned LN_CS = 0;
  localparam int unsigned LN_SCLK = 1;
  localparam int unsigned LN_DIN = 2;
  localparam int unsigned LN_SHUTDOWN_N = 3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CTRL = 2'b01,
    ST_CONV = 2'b10,
    ST_SHUT = 2'b11
  } asp_state_t;

endpackage : asp_pkg

// ==== asp_sync.sv ====
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module asp_sync
  import asp_pkg::*;
#(
  parameter int unsigned W = SYNC_W,
  parameter logic [W-1:0] RST_VAL = SYNC_RST
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } asp_sync_t;

  asp_sync_t r_r;
  asp_sync_t r_nxt;

  // First stage feeds only the second
  always_comb begin
    r_nxt.meta = d;
    r_nxt.stable = r_r.meta;
  end

  // Stage registers
  always_ff @(posedge clk) begin
    if (srst) begin
      r_r <= {RST_VAL, RST_VAL};
    end else begin
      r_r <= r_nxt;
    end
  end

  assign q = r_r.stable;

endmodule : asp_sync

// ==== asp_serial_port.sv ====
// Serial control and result port of an eight-channel converter
//
// Function
// RULE1: Data input sampled on each serial clock rise into shift register; the code shifts it in only up to the control byte's eighth bit.
// RULE2: Data input ignored while chip select is high.
// RULE3: Data output updated on each serial clock rise.
// RULE4: Data output and strobe undriven while chip select is high.
// RULE5: Strobe high one serial clock period just before MSB decision.
// RULE6: Shutdown input low forces shutdown, stopping conversion.
// RULE7: No internal conversion clock; every step follows serial clock.
// RULE8: Master keeps serial clock high time within 40 to 60 percent.
// RULE9: Conversion time is serial clock cycles times period, nothing more.
// RULE10: Leading zeros skipped; first one is control byte MSB.
// RULE11: Track after fifth bit's falling edge, hold after eighth's.
// RULE12: Result frame: three zeros, ten bits MSB first, two sub, one zero.
// RULE13: Straight binary when unipolar, two's complement when bipolar.
// RULE14: Chip select rise abandons partial control byte.
`timescale 1ns/1ps
module asp_serial_port
  import asp_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic DIN,
  input wire logic SHUTDOWN_N,
  input wire logic [CODE_BITS-1:0] ANALOG_CODE,
  output logic DOUT,
  output logic DOUT_OE,
  output logic FRAME_STROBE,
  output logic FRAME_STROBE_OE,
  output logic TRACK,
  output logic CONV_BUSY,
  output logic SHUTDOWN,
  output logic [CB_SEL_HI-CB_SEL_LO:0] CHANNEL_SEL,
  output logic UNIPOLAR,
  output logic SINGLE_ENDED,
  output logic [CB_PM_HI-CB_PM_LO:0] POWER_MODE
);

  typedef struct packed {
    asp_state_t state;
    logic sclk_prev;
    logic [CNT_W-1:0] bit_cnt;
    logic [STEP_W-1:0] step;
    logic [CTRL_BITS-1:0] shift;
    logic [CTRL_BITS-1:0] ctrl;
    logic [FRAME_BITS-1:0] frame;
    logic dout;
    logic dout_oe;
    logic strobe;
    logic strobe_oe;
    logic track;
    logic busy;
    logic shut;
  } asp_regs_t;

  asp_regs_t r_r;
  asp_regs_t r_nxt;
  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_s;
  logic cs_n_s;
  logic sclk_s;
  logic din_s;
  logic shutdown_n_n_s;
  logic sclk_rise;
  logic sclk_fall;

  // Result frame with coding applied
  function automatic logic [FRAME_BITS-1:0] build_frame(
    input logic [CODE_BITS-1:0] code,
    input logic uni
  );
    logic [CODE_BITS-1:0] res;
    res = code;
    if (!uni) begin
      res[CODE_BITS-1] = ~code[CODE_BITS-1]; // RULE13
    end
    return {{LEAD_ZEROS{1'b0}}, res, {TRAIL_ZEROS{1'b0}}}; // RULE12
  endfunction : build_frame

  // Pin synchronisers
  assign pins_raw[LN_CS] = CS_N;
  assign pins_raw[LN_SCLK] = SCLK;
  assign pins_raw[LN_DIN] = DIN;
  assign pins_raw[LN_SHUTDOWN_N] = SHUTDOWN_N;

  asp_sync #(
    .W(SYNC_W),
    .RST_VAL(SYNC_RST)
  ) u_sync (
    .clk(REF_CLK),
    .srst(SRST),
    .d(pins_raw),
    .q(pins_s)
  );

  assign cs_n_s = pins_s[LN_CS];
  assign sclk_s = pins_s[LN_SCLK];
  assign din_s = pins_s[LN_DIN];
  assign shutdown_n_n_s = pins_s[LN_SHUTDOWN_N];

  // Serial clock edges; both levels must last over one reference cycle
  assign sclk_rise = sclk_s & ~r_r.sclk_prev; // RULE8
  assign sclk_fall = ~sclk_s & r_r.sclk_prev; // RULE8

  // Next state
  always_comb begin
    r_nxt = r_r;
    r_nxt.sclk_prev = sclk_s;
    r_nxt.dout_oe = ~cs_n_s; // RULE4
    r_nxt.strobe_oe = ~cs_n_s; // RULE4
    r_nxt.shut = ~shutdown_n_n_s;
    if (!shutdown_n_n_s) begin
      // Hard shutdown overrides any selected power mode
      r_nxt.state = ST_SHUT; // RULE6
      r_nxt.bit_cnt = '0;
      r_nxt.step = '0;
      r_nxt.track = 1'b0;
      r_nxt.busy = 1'b0; // RULE6
      r_nxt.dout = 1'b0;
      r_nxt.strobe = 1'b0;
    end else if (cs_n_s) begin
      // Deselected: drop any partial byte or frame
      r_nxt.state = ST_IDLE; // RULE14
      r_nxt.bit_cnt = '0; // RULE14
      r_nxt.step = '0;
      r_nxt.track = 1'b0;
      r_nxt.busy = 1'b0;
      r_nxt.dout = 1'b0;
      r_nxt.strobe = 1'b0; // RULE2
    end else begin
      case (r_r.state)
        ST_SHUT: begin
          r_nxt.state = ST_IDLE;
        end
        ST_IDLE: begin
          if (sclk_rise) begin
            r_nxt.dout = 1'b0; // RULE3
            r_nxt.strobe = 1'b0;
            if (din_s) begin
              // First one seen is the byte's MSB
              r_nxt.shift = {{(CTRL_BITS-1){1'b0}}, 1'b1}; // RULE10
              r_nxt.bit_cnt = CNT_ONE; // RULE10
              r_nxt.state = ST_CTRL;
            end
          end
        end
        ST_CTRL: begin
          if (sclk_rise && r_r.bit_cnt < CNT_HOLD) begin
            r_nxt.shift = {r_r.shift[CTRL_BITS-2:0], din_s}; // RULE1
            r_nxt.bit_cnt = r_r.bit_cnt + CNT_ONE; // RULE1
            r_nxt.dout = 1'b0; // RULE3
          end
          if (sclk_fall && r_r.bit_cnt == CNT_TRACK) begin
            r_nxt.track = 1'b1; // RULE11
          end
          if (sclk_fall && r_r.bit_cnt == CNT_HOLD) begin
            // Hold: capture sample and start the conversion
            r_nxt.track = 1'b0; // RULE11
            r_nxt.ctrl = r_r.shift;
            r_nxt.frame = build_frame(ANALOG_CODE, r_r.shift[CB_UNI]);
            r_nxt.step = '0;
            r_nxt.busy = 1'b1;
            r_nxt.state = ST_CONV;
          end
        end
        ST_CONV: begin
          // Each step waits for a serial clock rise only
          if (sclk_rise) begin
            r_nxt.step = r_r.step + STEP_ONE; // RULE7
            r_nxt.dout = r_r.frame[FRAME_BITS-1]; // RULE3
            r_nxt.frame = {r_r.frame[FRAME_BITS-2:0], 1'b0}; // RULE12
            r_nxt.strobe = (r_r.step == STEP_STROBE - STEP_ONE); // RULE5
            if (r_r.step + STEP_ONE == STEP_LAST) begin
              r_nxt.busy = 1'b0; // RULE9
              r_nxt.state = ST_IDLE;
            end
          end
        end
        default: begin
          r_nxt.state = ST_IDLE;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      r_r.state <= ST_IDLE;
      r_r.sclk_prev <= 1'b0;
      r_r.bit_cnt <= '0;
      r_r.step <= '0;
      r_r.shift <= CTRL_RST;
      r_r.ctrl <= CTRL_RST;
      r_r.frame <= FRAME_RST;
      r_r.dout <= 1'b0;
      r_r.dout_oe <= 1'b0;
      r_r.strobe <= 1'b0;
      r_r.strobe_oe <= 1'b0;
      r_r.track <= 1'b0;
      r_r.busy <= 1'b0;
      r_r.shut <= 1'b0;
    end else begin
      r_r <= r_nxt;
    end
  end

  // Outputs straight from flops
  assign DOUT = r_r.dout;
  assign DOUT_OE = r_r.dout_oe;
  assign FRAME_STROBE = r_r.strobe;
  assign FRAME_STROBE_OE = r_r.strobe_oe;
  assign TRACK = r_r.track;
  assign CONV_BUSY = r_r.busy;
  assign SHUTDOWN = r_r.shut;
  assign CHANNEL_SEL = r_r.ctrl[CB_SEL_HI:CB_SEL_LO];
  assign UNIPOLAR = r_r.ctrl[CB_UNI];
  assign SINGLE_ENDED = r_r.ctrl[CB_SGL];
  assign POWER_MODE = r_r.ctrl[CB_PM_HI:CB_PM_LO];

endmodule : asp_serial_port

// ==== asp_props.sv ====
// Pin-level checks for the serial port
`timescale 1ns/1ps
module asp_props (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic SHUTDOWN_N,
  input wire logic DOUT,
  input wire logic DOUT_OE,
  input wire logic FRAME_STROBE,
  input wire logic FRAME_STROBE_OE,
  input wire logic TRACK,
  input wire logic CONV_BUSY,
  input wire logic SHUTDOWN
);
  logic sclk_r;
  logic [3:0] rise_r;
  logic [3:0] fall_r;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  // Cycles since the last raw clock rise and fall
  always_ff @(posedge REF_CLK) begin
    sclk_r <= SCLK;
    rise_r <= (SCLK && !sclk_r) ? 4'h0 : rise_r + {3'h0, rise_r != 4'hF};
    fall_r <= (!SCLK && sclk_r) ? 4'h0 : fall_r + {3'h0, fall_r != 4'hF};
  end
  oe_on_a: assert property (
    $fell(CS_N) |-> ##[2:4] DOUT_OE && FRAME_STROBE_OE)
    else $error("outputs not enabled");
  oe_off_a: assert property (
    $rose(CS_N) |-> ##[2:4] !DOUT_OE && !FRAME_STROBE_OE)
    else $error("outputs not released");
  strobe_width_a: assert property (
    $rose(FRAME_STROBE) |-> ##1 FRAME_STROBE [*8] ##[1:12] !FRAME_STROBE)
    else $error("strobe width wrong");
  strobe_conv_a: assert property (
    FRAME_STROBE |-> CONV_BUSY && FRAME_STROBE_OE)
    else $error("strobe outside conversion");
  dout_rise_a: assert property (
    $changed(DOUT) && DOUT_OE && !SHUTDOWN |-> rise_r inside {[1:5]})
    else $error("data changed off a clock rise");
  track_fall_a: assert property (
    $changed(TRACK) && !SHUTDOWN |-> fall_r inside {[1:5]})
    else $error("sampler moved off a clock fall");
  busy_step_a: assert property (
    $rose(CONV_BUSY) |-> !TRACK && fall_r inside {[1:5]})
    else $error("conversion not paced by clock");
  cs_gate_a: assert property (
    !DOUT_OE |-> !TRACK && !CONV_BUSY)
    else $error("input taken while deselected");
  shut_stop_a: assert property (
    $fell(SHUTDOWN_N) |-> ##[2:4] SHUTDOWN ##1 !CONV_BUSY)
    else $error("shutdown not entered");
endmodule : asp_props

bind asp_serial_port asp_props u_asp_props (.REF_CLK(REF_CLK),
  .SRST(SRST), .CS_N(CS_N), .SCLK(SCLK), .SHUTDOWN_N(SHUTDOWN_N),
  .DOUT(DOUT), .DOUT_OE(DOUT_OE), .FRAME_STROBE(FRAME_STROBE),
  .FRAME_STROBE_OE(FRAME_STROBE_OE), .TRACK(TRACK),
  .CONV_BUSY(CONV_BUSY), .SHUTDOWN(SHUTDOWN));

// ==== asp_master.sv ====
// Serial master model driving the port pins
`timescale 1ns/1ps
module asp_master (
  input wire logic clk,
  input wire logic dout,
  input wire logic strobe,
  output logic cs_n,
  output logic sclk,
  output logic din
);
  localparam int HALF = 8;
  // Idle pins: deselected, clock parked low
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  // Frame of z zeros then n bits of {cb, zeros}; samples before each rise from bit z+9 on, and once after the last
  task automatic frame(input logic [7:0] cb, input int z, input int n,
    input logic hi, output logic [15:0] rx, output logic [15:0] st);
    logic [23:0] w;
    w = {cb, 16'h0000};
    rx = 16'h0000;
    st = 16'h0000;
    cs_n <= hi;
    repeat (HALF) @(posedge clk);
    for (int j = 0; j < z + n; j++) begin
      din <= (j < z) ? 1'b0 : w[23 - (j - z)];
      repeat (HALF) @(posedge clk);
      if (j >= z + 9) begin
        rx = {rx[14:0], dout};
        st = {st[14:0], strobe};
      end
      sclk <= 1'b1;
      repeat (HALF) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (HALF) @(posedge clk);
    rx = {rx[14:0], dout};
    st = {st[14:0], strobe};
    cs_n <= 1'b1;
    din <= ~din; // Released line keeps no stale value
    repeat (32) @(posedge clk);
  endtask : frame
endmodule : asp_master

// ==== testbench.sv ====
// Self-checking bench for the serial control port
`timescale 1ns/1ps
module testbench;
  import asp_pkg::*;
  localparam int LIMIT = 20000;
  logic REF_CLK, SRST, SHUTDOWN_N, CS_N, SCLK, DIN;
  logic [CODE_BITS-1:0] ANALOG_CODE;
  logic DOUT, DOUT_OE, FRAME_STROBE, FRAME_STROBE_OE;
  logic TRACK, CONV_BUSY, SHUTDOWN, UNIPOLAR, SINGLE_ENDED;
  logic [CB_SEL_HI-CB_SEL_LO:0] CHANNEL_SEL;
  logic [CB_PM_HI-CB_PM_LO:0] POWER_MODE;
  logic [15:0] rx, st;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  int trk_cnt = 0;
  int busy_cnt = 0;
  wire dout_w = DOUT_OE ? DOUT : 1'bz;
  wire strb_w = FRAME_STROBE_OE ? FRAME_STROBE : 1'bz;
  wire [15:0] flds = {8'h00, CONV_BUSY, CHANNEL_SEL, UNIPOLAR,
    SINGLE_ENDED, POWER_MODE};
  asp_serial_port u_asp_serial_port (.REF_CLK, .SRST, .CS_N, .SCLK, .DIN,
    .SHUTDOWN_N, .ANALOG_CODE, .DOUT, .DOUT_OE, .FRAME_STROBE,
    .FRAME_STROBE_OE, .TRACK, .CONV_BUSY, .SHUTDOWN, .CHANNEL_SEL,
    .UNIPOLAR, .SINGLE_ENDED, .POWER_MODE);
  asp_master u_asp_master (.clk(REF_CLK), .dout(dout_w), .strobe(strb_w),
    .cs_n(CS_N), .sclk(SCLK), .din(DIN));
  // System clock, 4 ns
  initial begin
    REF_CLK = 1'b0;
    forever #2 REF_CLK = ~REF_CLK;
  end
  // Hang guard
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_fail++;
      end_of_test();
    end
  end
  // Cycles spent tracking and converting
  always @(posedge REF_CLK) begin
    if (TRACK === 1'b1) begin
      trk_cnt++;
    end
    if (CONV_BUSY === 1'b1) begin
      busy_cnt++;
    end
  end
  task automatic end_of_test();
    if (n_fail == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask : check
  // Full conversion; bipolar flips the code MSB
  task automatic s_conv(input logic [7:0] cb, input logic [11:0] cd,
    input int z);
    logic [11:0] c;
    int t0;
    int b0;
    c = cb[CB_UNI] ? cd : {~cd[11], cd[10:0]};
    t0 = trk_cnt;
    b0 = busy_cnt;
    ANALOG_CODE <= cd;
    u_asp_master.frame(cb, z, 24, 1'b0, rx, st);
    check(rx, {3'b000, c, 1'b0});
    check(st, 16'h2000);
    check(flds, {9'h000, cb[6:0]});
    check({14'h0000, DOUT_OE, FRAME_STROBE_OE}, 16'h0000);
    check(16'(trk_cnt - t0), 16'h0030);
    check(16'(busy_cnt - b0), 16'h00F8);
  endtask : s_conv
  // Clocking while deselected
  task automatic s_ignore(input logic [7:0] prev);
    u_asp_master.frame(8'hFF, 0, 24, 1'b1, rx, st);
    check(rx, 16'hzzzz);
    check(st, 16'hzzzz);
    check(flds, {9'h000, prev[6:0]});
  endtask : s_ignore
  // Frame attempted during shutdown
  task automatic s_shut(input logic [7:0] prev);
    int b0;
    b0 = busy_cnt;
    SHUTDOWN_N <= 1'b0;
    repeat (8) @(posedge REF_CLK);
    check({15'h0000, SHUTDOWN}, 16'h0001);
    u_asp_master.frame(8'hC1, 0, 24, 1'b0, rx, st);
    check(rx | st, 16'h0000);
    check(16'(busy_cnt - b0), 16'h0000);
    check(flds, {9'h000, prev[6:0]});
    SHUTDOWN_N <= 1'b1;
    repeat (8) @(posedge REF_CLK);
  endtask : s_shut
  // Main sequence
  initial begin
    SRST = 1'b1;
    SHUTDOWN_N = 1'b1;
    ANALOG_CODE = 12'h000;
    repeat (3) @(posedge REF_CLK);
    SRST <= 1'b0;
    repeat (4) @(posedge REF_CLK);
    s_conv(8'hFF, 12'hFFF, 0);
    s_conv(8'hA5, 12'h801, 3);
    s_conv(8'hC8, 12'h000, 1);
    s_ignore(8'hC8);
    u_asp_master.frame(8'hFF, 0, 4, 1'b0, rx, st);
    check(flds, {9'h000, 7'h48});
    s_conv(8'h96, 12'h5A3, 2);
    s_shut(8'h96);
    s_conv(8'hB6, 12'h3C5, 0);
    end_of_test();
  end
endmodule : testbench
